/* File: dmars_far_model.sv */
// Far side model: bus owner answering hold, one requesting peripheral
`timescale 1ns/1ps
module dmars_far_model (
    input  wire logic       clk_sys_i,
    input  wire logic       arst_n_i,
    input  wire logic       hold_request_i,
    input  wire logic [3:0] grant_i,
    input  wire logic       grant_high_i,
    input  wire logic       req_low_i,
    input  wire logic [1:0] chan_i,
    input  wire logic [3:0] lag_i,
    input  wire logic       load_i,
    input  wire logic [7:0] jobs_i,
    output logic      [3:0] request_o,
    output logic            hold_grant_o
);
    logic [7:0] pend_q;
    logic [3:0] wait_q;
    logic       seen_q;
    logic       mine;
    assign mine = grant_i[chan_i] ^ ~grant_high_i;
    // Jobs counted down once per grant; bus released lag+1 cycles after hold request
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pend_q <= 8'h00;
            wait_q <= 4'h0;
            seen_q <= 1'b0;
            hold_grant_o <= 1'b0;
        end else begin
            seen_q <= mine;
            if (load_i)
                pend_q <= jobs_i;
            else if (mine && !seen_q && pend_q != 8'h00)
                pend_q <= pend_q - 8'h01;
            wait_q <= !hold_request_i ? 4'h0 :
                      (wait_q == lag_i) ? wait_q : wait_q + 4'h1;
            hold_grant_o <= hold_request_i && (wait_q == lag_i);
        end
    end
    // Request held until own grant shows, idle lines at inactive level
    always_comb begin
        request_o = {4{req_low_i}};
        request_o[chan_i] = req_low_i ^ (pend_q != 8'h00 && !mine && !seen_q);
    end
endmodule : dmars_far_model

/* File: dmars_pkg.sv */
// Shared constants and types for the DMA channel register set
package dmars_pkg;

    // Host register port offsets (4-bit address)
    localparam logic [3:0] ADR_CH_FIRST     = 4'h0; // 0..7: address/count
    localparam logic [3:0] ADR_CTRL_STATUS  = 4'h8; // wr control, rd flags
    localparam logic [3:0] ADR_SW_REQUEST   = 4'h9;
    localparam logic [3:0] ADR_MASK_SINGLE  = 4'hA;
    localparam logic [3:0] ADR_XFER_CONFIG  = 4'hB;
    localparam logic [3:0] ADR_BYTE_PTR_CLR = 4'hC;
    localparam logic [3:0] ADR_MASTER_CLEAR = 4'hD; // rd scratch_data
    localparam logic [3:0] ADR_MASK_CLEAR   = 4'hE;
    localparam logic [3:0] ADR_MASK_ALL     = 4'hF; // rd request_masks

    // global_control field positions
    localparam int CTL_DISABLE    = 2;
    localparam int CTL_COMPRESSED = 3;
    localparam int CTL_EXT_WRITE  = 5;
    localparam int CTL_REQ_LOW    = 6;
    localparam int CTL_GRANT_HIGH = 7;

    // channel_transfer_config field positions (6 bits)
    localparam int CFG_AUTOINIT  = 2;
    localparam int CFG_DECREMENT = 3;
    localparam logic [1:0] XFER_VERIFY = 2'h0;
    localparam logic [1:0] XFER_WRITE  = 2'h1; // io read, memory write
    localparam logic [1:0] XFER_READ   = 2'h2; // memory read, io write

    // Reset values
    localparam logic [7:0] CTL_RESET   = 8'h00;
    localparam logic [3:0] MASK_RESET  = 4'hF;
    localparam logic [7:0] READ_ONES   = 8'hF0;
    localparam logic [15:0] CNT_LAST   = 16'h0000;

    // Strobe widths in controller clock periods
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int T_CY_PS         = CLK_PERIOD_PS;
    localparam int STROBE_ONE_TCY  = 1;
    localparam int STROBE_TWO_TCY  = 2;
    localparam logic [1:0] STROBE_SHORT_CYC =
        2'((STROBE_ONE_TCY * T_CY_PS) / CLK_PERIOD_PS);
    localparam logic [1:0] STROBE_LONG_CYC =
        2'((STROBE_TWO_TCY * T_CY_PS) / CLK_PERIOD_PS);

    // Engine states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLD_WAIT,
        ST_STROBE,
        ST_FINISH
    } dmars_state_t;

    // Pin inputs that cross into the clock domain
    typedef struct packed {
        logic       cs_n;
        logic       ior_n;
        logic       iow_n;
        logic [3:0] addr;
        logic [7:0] data;
        logic [3:0] req;
        logic       hlda;
    } dmars_pins_t;

    localparam dmars_pins_t PINS_IDLE = '{
        cs_n: 1'b1, ior_n: 1'b1, iow_n: 1'b1, addr: 4'h0,
        data: 8'h00, req: 4'h0, hlda: 1'b0};

    // Transfer strobe set, active high inside the block
    typedef struct packed {
        logic io_read_strobe;
        logic io_write_strobe;
        logic memory_read_strobe;
        logic memory_write_strobe;
    } dmars_strobe_t;

endpackage : dmars_pkg

/* File: dmars_sync.sv */
// Two-flop synchroniser for a packed vector of pin inputs
`timescale 1ns/1ps
module dmars_sync #(
    parameter int              WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk_sys_i,
    input  wire logic             arst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : dmars_sync

/* File: dmars_top.sv */
// Four-channel DMA controller register set and transfer strobes
// How it works
// - Holds four address/count pairs of each kind, four 6-bit configs, masks, requests, control, flags and scratch storage.
// - Each channel keeps start address and start count copies of what was last loaded.
// - Auto-initialize copies the start values back into the running address and count.
// - A host byte write to a running address or count while idle also writes the start copy.
// - Start registers are never returned on any host read.
// - The 8-bit global control register clears on reset and on master clear.
// - Write strobes last one clock, or two when extended write is selected.
// - Read strobes last two clocks, or one when compressed timing is selected.
// - Request and grant sense are each selectable high or low by control bits.
// - Reset clears control, flags, requests, scratch, config pointer and byte order, sets all masks, leaves the engine idle.
// - Running count decrements per transfer and terminal count fires on wrap from zero.
// - Auto-initialize happens only at the end of process of that channel.
`timescale 1ns/1ps
module dmars_top (
    input  wire logic       clk_sys_i,
    input  wire logic       arst_n_i,
    input  wire logic       cs_n_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_n_o,
    input  wire logic       io_read_strobe_n_i,
    output logic            io_read_strobe_n_o,
    input  wire logic       io_write_strobe_n_i,
    output logic            io_write_strobe_n_o,
    output logic            io_strobe_oe_n_o,
    output logic            memory_read_strobe_n_o,
    output logic            memory_write_strobe_n_o,
    input  wire logic [3:0] channel_request_line_i,
    output logic      [3:0] channel_grant_line_o,
    output logic            hold_request_o,
    input  wire logic       hold_grant_i,
    output logic            address_enable_o,
    output logic     [15:0] address_o,
    output logic            terminal_count_o
);

    typedef struct packed {
        logic [3:0][15:0]       start_addr;
        logic [3:0][15:0]       start_cnt;
        logic [3:0][15:0]       run_addr;
        logic [3:0][15:0]       run_cnt;
        logic [3:0][5:0]        cfg;
        logic [7:0]             ctl;
        logic [7:0]             flags;
        logic [7:0]             scratch_data;
        logic [15:0]            scratch_address;
        logic [15:0]            scratch_count;
        logic [3:0]             mask;
        logic [3:0]             sw_req;
        logic [1:0]             cfg_ptr;
        logic                   byte_hi;
        dmars_pkg::dmars_state_t state;
        logic [1:0]             chan;
        logic [1:0]             cnt;
        dmars_pkg::dmars_pins_t prev;
        logic [3:0]             grant;
        logic [7:0]             dout;
        logic                   doe_n;
        dmars_pkg::dmars_strobe_t stb;
        logic                   io_oe_n;
        logic [3:0]             grant_pin;
        logic                   hrq;
        logic                   aen;
        logic [15:0]            aout;
        logic                   tc;
    } dmars_regs_t;

    dmars_regs_t            q;
    dmars_regs_t            d;
    dmars_pkg::dmars_pins_t pins_async;
    dmars_pkg::dmars_pins_t pins;

    assign pins_async = '{cs_n: cs_n_i, ior_n: io_read_strobe_n_i,
                          iow_n: io_write_strobe_n_i, addr: addr_i,
                          data: data_i, req: channel_request_line_i,
                          hlda: hold_grant_i};

    // Every pin input passes two flops before use
    dmars_sync #(
        .WIDTH     ($bits(dmars_pkg::dmars_pins_t)),
        .RESET_VAL (dmars_pkg::PINS_IDLE)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .async_i   (pins_async),
        .sync_o    (pins)
    );

    // Strobes for one step of the active window
    function automatic dmars_pkg::dmars_strobe_t strobe_at(
        input logic [1:0] step,
        input logic [1:0] kind,
        input logic [7:0] ctl
    );
        logic [1:0] rd_len;
        logic [1:0] wr_len;
        logic [1:0] len;
        logic       rd_on;
        logic       wr_on;
        rd_len = ctl[dmars_pkg::CTL_COMPRESSED] ?
                 dmars_pkg::STROBE_SHORT_CYC : dmars_pkg::STROBE_LONG_CYC;
        wr_len = ctl[dmars_pkg::CTL_EXT_WRITE] ?
                 dmars_pkg::STROBE_LONG_CYC : dmars_pkg::STROBE_SHORT_CYC;
        len    = (rd_len > wr_len) ? rd_len : wr_len;
        rd_on  = step < rd_len;
        wr_on  = step >= (len - wr_len);
        strobe_at.io_read_strobe  = rd_on && (kind == dmars_pkg::XFER_WRITE);
        strobe_at.memory_write_strobe = wr_on && (kind == dmars_pkg::XFER_WRITE);
        strobe_at.memory_read_strobe = rd_on && (kind == dmars_pkg::XFER_READ);
        strobe_at.io_write_strobe  = wr_on && (kind == dmars_pkg::XFER_READ);
    endfunction : strobe_at

    // Last step of the active window
    function automatic logic [1:0] last_step(input logic [7:0] ctl);
        logic [1:0] rd_len;
        logic [1:0] wr_len;
        rd_len = ctl[dmars_pkg::CTL_COMPRESSED] ?
                 dmars_pkg::STROBE_SHORT_CYC : dmars_pkg::STROBE_LONG_CYC;
        wr_len = ctl[dmars_pkg::CTL_EXT_WRITE] ?
                 dmars_pkg::STROBE_LONG_CYC : dmars_pkg::STROBE_SHORT_CYC;
        last_step = ((rd_len > wr_len) ? rd_len : wr_len) - 2'h1;
    endfunction : last_step

    // Next-state logic: host port, then the transfer engine
    always_comb begin
        logic       idle;
        logic       wr_evt;
        logic       rd_evt;
        logic [3:0] wa;
        logic [7:0] wd;
        logic [1:0] ch;
        logic [3:0] req_act;
        logic [3:0] pend;
        logic [1:0] pick;
        logic [1:0] kind;
        logic [7:0] rbyte;
        d       = q;
        d.prev  = pins;
        d.tc    = 1'b0;
        idle    = (q.state == dmars_pkg::ST_IDLE);
        wa      = q.prev.addr;
        wd      = q.prev.data;
        ch      = wa[2:1];
        wr_evt  = idle && !q.prev.cs_n && !q.prev.iow_n && pins.iow_n;
        rd_evt  = idle && !q.prev.cs_n && !q.prev.ior_n && pins.ior_n;
        // Request sense follows control; bits 7:4 ignore the mask
        req_act = q.ctl[dmars_pkg::CTL_REQ_LOW] ? ~pins.req : pins.req;
        d.flags[7:4] = req_act;
        pick    = 2'h0;
        kind    = q.cfg[q.chan][1:0];
        rbyte   = 8'h00;

        // Host writes, taken at the trailing edge of the write strobe
        if (wr_evt) begin
            if (!wa[3]) begin
                if (wa[0]) begin
                    if (q.byte_hi) begin
                        d.run_cnt[ch][15:8]   = wd;
                        d.start_cnt[ch][15:8] = wd;
                    end else begin
                        d.run_cnt[ch][7:0]    = wd;
                        d.start_cnt[ch][7:0]  = wd;
                    end
                end else begin
                    if (q.byte_hi) begin
                        d.run_addr[ch][15:8]   = wd;
                        d.start_addr[ch][15:8] = wd;
                    end else begin
                        d.run_addr[ch][7:0]    = wd;
                        d.start_addr[ch][7:0]  = wd;
                    end
                end
                d.byte_hi = !q.byte_hi;
            end else begin
                unique case (wa)
                    dmars_pkg::ADR_CTRL_STATUS:  d.ctl = wd;
                    dmars_pkg::ADR_SW_REQUEST:   d.sw_req[wd[1:0]] = wd[2];
                    dmars_pkg::ADR_MASK_SINGLE:  d.mask[wd[1:0]] = wd[2];
                    dmars_pkg::ADR_XFER_CONFIG:  d.cfg[wd[1:0]] = wd[7:2];
                    dmars_pkg::ADR_BYTE_PTR_CLR: d.byte_hi = 1'b0;
                    dmars_pkg::ADR_MASTER_CLEAR: begin
                        d.ctl             = dmars_pkg::CTL_RESET;
                        d.flags           = 8'h00;
                        d.sw_req          = 4'h0;
                        d.scratch_data    = 8'h00;
                        d.scratch_address = 16'h0000;
                        d.scratch_count   = 16'h0000;
                        d.cfg_ptr         = 2'h0;
                        d.byte_hi         = 1'b0;
                        d.mask            = dmars_pkg::MASK_RESET;
                    end
                    dmars_pkg::ADR_MASK_CLEAR:   d.mask = 4'h0;
                    dmars_pkg::ADR_MASK_ALL:     d.mask = wd[3:0];
                    default: ;
                endcase
            end
        end

        // Read data; start copies have no read path
        if (!wa[3]) begin
            rbyte = wa[0] ?
                (q.byte_hi ? q.run_cnt[ch][15:8] : q.run_cnt[ch][7:0]) :
                (q.byte_hi ? q.run_addr[ch][15:8] : q.run_addr[ch][7:0]);
        end else begin
            unique case (wa)
                dmars_pkg::ADR_CTRL_STATUS:  rbyte = q.flags;
                dmars_pkg::ADR_SW_REQUEST:
                    rbyte = dmars_pkg::READ_ONES | {4'h0, q.sw_req};
                dmars_pkg::ADR_XFER_CONFIG:  rbyte = {q.cfg[q.cfg_ptr], 2'h3};
                dmars_pkg::ADR_MASTER_CLEAR: rbyte = q.scratch_data;
                dmars_pkg::ADR_MASK_ALL:
                    rbyte = dmars_pkg::READ_ONES | {4'h0, q.mask};
                default:                     rbyte = 8'h00;
            endcase
        end
        d.dout  = rbyte;
        d.doe_n = !(idle && !pins.cs_n && !pins.ior_n);

        // Read side effects at the trailing edge of the read strobe
        if (rd_evt) begin
            if (!wa[3]) begin
                d.byte_hi = !q.byte_hi;
            end else if (wa == dmars_pkg::ADR_CTRL_STATUS) begin
                d.flags[3:0] = 4'h0;
            end else if (wa == dmars_pkg::ADR_XFER_CONFIG) begin
                d.cfg_ptr = q.cfg_ptr + 2'h1;
            end
        end

        // Hardware requests must stay up until granted
        pend = (req_act & ~q.mask) | q.sw_req;
        for (int i = 3; i >= 0; i--) begin
            if (pend[i]) begin
                pick = 2'(i);
            end
        end

        // Transfer engine; terminal count set wins over a flag clear
        unique case (q.state)
            dmars_pkg::ST_IDLE: begin
                if (!q.ctl[dmars_pkg::CTL_DISABLE] && (pend != 4'h0)) begin
                    d.hrq   = 1'b1;
                    d.state = dmars_pkg::ST_HOLD_WAIT;
                end
            end
            dmars_pkg::ST_HOLD_WAIT: begin
                if (pins.hlda) begin
                    d.chan     = pick;
                    d.aen      = 1'b1;
                    d.aout     = q.run_addr[pick];
                    d.grant    = 4'(1) << pick;
                    d.io_oe_n  = 1'b0;
                    d.cnt      = 2'h0;
                    d.stb      = strobe_at(2'h0, q.cfg[pick][1:0], q.ctl);
                    d.state    = dmars_pkg::ST_STROBE;
                end
            end
            dmars_pkg::ST_STROBE: begin
                if (q.cnt == last_step(q.ctl)) begin
                    d.stb   = '0;
                    d.state = dmars_pkg::ST_FINISH;
                end else begin
                    d.cnt = q.cnt + 2'h1;
                    d.stb = strobe_at(d.cnt, kind, q.ctl);
                end
            end
            dmars_pkg::ST_FINISH: begin
                d.run_cnt[q.chan] = q.run_cnt[q.chan] - 16'h0001;
                d.run_addr[q.chan] = q.cfg[q.chan][dmars_pkg::CFG_DECREMENT] ?
                    q.run_addr[q.chan] - 16'h0001 :
                    q.run_addr[q.chan] + 16'h0001;
                d.sw_req[q.chan] = 1'b0;
                if (q.run_cnt[q.chan] == dmars_pkg::CNT_LAST) begin
                    d.tc = 1'b1;
                    d.flags[q.chan] = 1'b1;
                    if (q.cfg[q.chan][dmars_pkg::CFG_AUTOINIT]) begin
                        d.run_addr[q.chan] = q.start_addr[q.chan];
                        d.run_cnt[q.chan]  = q.start_cnt[q.chan];
                    end else begin
                        d.mask[q.chan] = 1'b1;
                    end
                end
                d.grant   = 4'h0;
                d.hrq     = 1'b0;
                d.aen     = 1'b0;
                d.io_oe_n = 1'b1;
                d.state   = dmars_pkg::ST_IDLE;
            end
        endcase

        // Grant pins follow the selected sense
        d.grant_pin = d.ctl[dmars_pkg::CTL_GRANT_HIGH] ?
                      d.grant : ~d.grant;
    end

    // Single state register; reset as the controller's power-on state
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q           <= '0;
            q.ctl       <= dmars_pkg::CTL_RESET;
            q.mask      <= dmars_pkg::MASK_RESET;
            q.state     <= dmars_pkg::ST_IDLE;
            q.prev      <= dmars_pkg::PINS_IDLE;
            q.doe_n     <= 1'b1;
            q.io_oe_n   <= 1'b1;
            q.grant_pin <= 4'hF;
        end else begin
            q <= d;
        end
    end

    // Pins, all straight from the state flops
    assign data_o                  = q.dout;
    assign data_oe_n_o             = q.doe_n;
    assign io_read_strobe_n_o      = !q.stb.io_read_strobe;
    assign io_write_strobe_n_o     = !q.stb.io_write_strobe;
    assign io_strobe_oe_n_o        = q.io_oe_n;
    assign memory_read_strobe_n_o  = !q.stb.memory_read_strobe;
    assign memory_write_strobe_n_o = !q.stb.memory_write_strobe;
    assign channel_grant_line_o    = q.grant_pin;
    assign hold_request_o          = q.hrq;
    assign address_enable_o        = q.aen;
    assign address_o               = q.aout;
    assign terminal_count_o        = q.tc;

endmodule : dmars_top

/* File: dmars_top_props.sv */
// Port checker for the DMA channel register set
`timescale 1ns/1ps
module dmars_top_props (
    input wire logic       clk_sys_i,
    input wire logic       arst_n_i,
    input wire logic       cs_n_i,
    input wire logic       io_read_strobe_n_i,
    input wire logic       data_oe_n_o,
    input wire logic       io_strobe_oe_n_o,
    input wire logic       memory_read_strobe_n_o,
    input wire logic       memory_write_strobe_n_o,
    input wire logic [3:0] channel_grant_line_o,
    input wire logic       hold_request_o,
    input wire logic       address_enable_o,
    input wire logic       terminal_count_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    // Transfer window opens for at least two cycles
    sequence s_open;
        address_enable_o ##1 address_enable_o;
    endsequence
    property p_window;
        $rose(address_enable_o) |-> s_open ##[1:2] !address_enable_o;
    endproperty
    a_window: assert property (p_window) else $error("window length");
    property p_mr_width;
        $fell(memory_read_strobe_n_o) |-> ##2 memory_read_strobe_n_o;
    endproperty
    a_mr_width: assert property (p_mr_width) else $error("read too long");
    property p_mw_width;
        $fell(memory_write_strobe_n_o) |-> ##[1:2] $rose(memory_write_strobe_n_o);
    endproperty
    a_mw_width: assert property (p_mw_width) else $error("write width");
    // Memory strobes only inside an owned transfer window
    property p_strobe_owned;
        !(memory_read_strobe_n_o && memory_write_strobe_n_o)
            |-> address_enable_o && !io_strobe_oe_n_o;
    endproperty
    a_strobe_owned: assert property (p_strobe_owned) else $error("stray");
    property p_grant_one;
        address_enable_o |-> $onehot(channel_grant_line_o)
            || $onehot(~channel_grant_line_o);
    endproperty
    a_grant_one: assert property (p_grant_one) else $error("grant");
    property p_aen_hold;
        address_enable_o |-> hold_request_o;
    endproperty
    a_aen_hold: assert property (p_aen_hold) else $error("no hold");
    property p_tc_pulse;
        $rose(terminal_count_o) |=> !terminal_count_o;
    endproperty
    a_tc_pulse: assert property (p_tc_pulse) else $error("tc width");
    property p_tc_end;
        terminal_count_o |-> $fell(address_enable_o) && !hold_request_o;
    endproperty
    a_tc_end: assert property (p_tc_end) else $error("tc moment");
    property p_read_ans;
        $fell(data_oe_n_o) |-> $past(!cs_n_i && !io_read_strobe_n_i, 2);
    endproperty
    a_read_ans: assert property (p_read_ans) else $error("early read");
    property p_host_idle;
        !data_oe_n_o |-> io_strobe_oe_n_o && !address_enable_o;
    endproperty
    a_host_idle: assert property (p_host_idle) else $error("bus clash");
endmodule : dmars_top_props

/* File: testbench.sv */
// Self-checking bench for the DMA channel register set
`timescale 1ns/1ps
module testbench;
    logic clk_sys_i = 1'b0, arst_n_i = 1'b0, cs_n_i = 1'b1;
    logic io_read_strobe_n_i = 1'b1, io_write_strobe_n_i = 1'b1;
    logic [3:0] addr_i = 4'h0, channel_request_line_i, channel_grant_line_o;
    logic [7:0] data_i = 8'h00, data_o, q, jobs = 8'h00;
    logic data_oe_n_o, io_read_strobe_n_o, io_write_strobe_n_o;
    logic io_strobe_oe_n_o, memory_read_strobe_n_o, memory_write_strobe_n_o;
    logic hold_request_o, hold_grant_i, address_enable_o, terminal_count_o;
    logic [15:0] address_o, v, a0, cnt;
    logic g_high = 1'b0, r_low = 1'b0, load = 1'b0, aen_q = 1'b0;
    logic [1:0] chan = 2'h0;
    logic [3:0] lag = 4'h0;
    logic [3:0] ra[4] = '{4'hF, 4'h9, 4'h8, 4'hD};
    logic [7:0] rv[4] = '{8'hFF, 8'hF0, 8'h00, 8'h00};
    int n_fail = 0, n_compared = 0, cycles = 0, seed = 31;
    int n_tc = 0, n_xfer = 0, rd_run = 0, wr_run = 0, rd_w = 0, wr_w = 0;
    wire rd_lo = !memory_read_strobe_n_o
                 || (!io_read_strobe_n_o && !io_strobe_oe_n_o);
    wire wr_lo = !memory_write_strobe_n_o
                 || (!io_write_strobe_n_o && !io_strobe_oe_n_o);
    always #2.5 clk_sys_i = ~clk_sys_i;
    dmars_top dut_u (.clk_sys_i, .arst_n_i, .cs_n_i, .addr_i, .data_i,
        .data_o, .data_oe_n_o, .io_read_strobe_n_i, .io_read_strobe_n_o,
        .io_write_strobe_n_i, .io_write_strobe_n_o, .io_strobe_oe_n_o,
        .memory_read_strobe_n_o, .memory_write_strobe_n_o,
        .channel_request_line_i, .channel_grant_line_o, .hold_request_o,
        .hold_grant_i, .address_enable_o, .address_o, .terminal_count_o);
    dmars_far_model far_u (.clk_sys_i, .arst_n_i,
        .hold_request_i(hold_request_o), .grant_i(channel_grant_line_o),
        .grant_high_i(g_high), .req_low_i(r_low), .chan_i(chan),
        .lag_i(lag), .load_i(load), .jobs_i(jobs),
        .request_o(channel_request_line_i), .hold_grant_o(hold_grant_i));
    task automatic tally_and_finish;
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    // One host strobe, long enough to cross the pin synchronisers
    task automatic acc(input logic rd, input logic [3:0] a,
                       input logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        cs_n_i = 1'b0;
        addr_i = a;
        data_i = d;
        io_read_strobe_n_i = !rd;
        io_write_strobe_n_i = rd;
        repeat (5) @(posedge clk_sys_i);
        q = data_o;
        #1;
        io_read_strobe_n_i = 1'b1;
        io_write_strobe_n_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        cs_n_i = 1'b1;
        data_i = ~d; // Released bus no longer shows the old byte
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask : acc
    task automatic wr16(input logic [3:0] a, input logic [15:0] d);
        acc(1'b0, a, d[7:0]);
        acc(1'b0, a, d[15:8]);
    endtask : wr16
    task automatic rd16(input logic [3:0] a);
        acc(1'b1, a, 8'h00);
        v[7:0] = q;
        acc(1'b1, a, 8'h00);
        v[15:8] = q;
    endtask : rd16
    // Program a channel, let the peripheral run count+1 jobs
    task automatic xfer(input logic [1:0] ch, input logic [7:0] mode);
        a0 = 16'($random(seed));
        cnt = 16'($random(seed) & 3);
        acc(1'b0, 4'hC, 8'h00);
        wr16({1'b0, ch, 1'b0}, a0);
        wr16({1'b0, ch, 1'b1}, cnt);
        rd16({1'b0, ch, 1'b0});
        check(v, a0);
        rd16({1'b0, ch, 1'b1});
        check(v, cnt);
        acc(1'b0, 4'hB, {mode[7:2], ch});
        acc(1'b1, 4'hB, 8'h00);
        check(q, {mode[7:2], 2'b11});
        acc(1'b0, 4'hA, {6'h00, ch});
        n_tc = 0;
        n_xfer = 0;
        chan = ch;
        lag = 4'($random(seed) & 7);
        jobs = cnt[7:0] + 8'h01;
        load = 1'b1;
        @(posedge clk_sys_i);
        #1;
        load = 1'b0;
        for (int i = 0; i < 2000 && n_tc == 0; i++)
            @(posedge clk_sys_i);
        repeat (8) @(posedge clk_sys_i);
        check(16'(n_xfer), cnt + 16'h0001);
    endtask : xfer
    // Cycle limit, strobe widths, transfer and terminal count tallies
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            tally_and_finish();
        end
        rd_w = (!rd_lo && rd_run > 0) ? rd_run : rd_w;
        rd_run = rd_lo ? rd_run + 1 : 0;
        wr_w = (!wr_lo && wr_run > 0) ? wr_run : wr_w;
        wr_run = wr_lo ? wr_run + 1 : 0;
        if (terminal_count_o === 1'b1)
            n_tc++;
        if (address_enable_o === 1'b1 && !aen_q) begin
            check(address_o, a0 + 16'(n_xfer));
            n_xfer++;
        end
        aen_q = (address_enable_o === 1'b1);
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        #1;
        arst_n_i = 1'b1;
        repeat (3) @(posedge clk_sys_i);
        foreach (ra[i]) begin
            acc(1'b1, ra[i], 8'h00);
            check(q, rv[i]);
        end
        // Memory read to io write, normal timing, no auto-initialize
        xfer(2'd0, 8'h08);
        check(16'(rd_w), 16'h0002);
        check(16'(wr_w), 16'h0001);
        rd16(4'h1);
        check(v, 16'hFFFF);
        acc(1'b1, 4'h8, 8'h00);
        check(q, 8'h01);
        acc(1'b1, 4'hF, 8'h00);
        check(q, 8'hFF);
        // Inverted senses, compressed read, extended write, auto-init
        acc(1'b0, 4'h8, 8'hE8);
        g_high = 1'b1;
        r_low = 1'b1;
        check({12'h000, channel_grant_line_o}, 16'h0000);
        xfer(2'd1, 8'h14);
        check(16'(rd_w), 16'h0001);
        check(16'(wr_w), 16'h0002);
        rd16(4'h2);
        check(v, a0);
        rd16(4'h3);
        check(v, cnt);
        acc(1'b1, 4'hF, 8'h00);
        check(q, 8'hFD);
        // Master clear returns control and masks to reset state
        acc(1'b0, 4'hD, 8'h00);
        check({12'h000, channel_grant_line_o}, 16'h000F);
        acc(1'b1, 4'hF, 8'h00);
        check(q, 8'hFF);
        tally_and_finish();
    end
endmodule : testbench
bind dmars_top dmars_top_props chk_u (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .cs_n_i(cs_n_i),
    .io_read_strobe_n_i(io_read_strobe_n_i), .data_oe_n_o(data_oe_n_o),
    .io_strobe_oe_n_o(io_strobe_oe_n_o),
    .memory_read_strobe_n_o(memory_read_strobe_n_o),
    .memory_write_strobe_n_o(memory_write_strobe_n_o),
    .channel_grant_line_o(channel_grant_line_o),
    .hold_request_o(hold_request_o), .address_enable_o(address_enable_o),
    .terminal_count_o(terminal_count_o));
